// ==== bus_mem_model.sv ====
/*
 * bus-side partner: byte memory that answers each request after a delay.
 * assumes one request at a time, held until acknowledged.
 */
`timescale 1ns/1ns
`default_nettype none
module bus_mem_model import dlink_pkg::*; #(
    parameter int DELAY = 3
) (
    input wire logic clock_in,
    input wire bus_t bus_in,
    input wire logic stall_in,
    output logic ack_out,
    output logic [31:0] rdata_out
);
    logic [7:0] mem [0:255]; // byte storage, low address byte only
    int cnt; // cycles the request has waited
    initial begin
        foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
        ack_out = 1'b0;
        rdata_out = 32'h0;
        cnt = 0;
    end
    ////////////////////////////////////////////////////////////////////////
    // buffered bus answer
    always @(posedge clock_in) begin
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out; // outside the answer every bit toggles each cycle
        if (!bus_in.req || ack_out) begin
            cnt <= 0;
        end else if (!stall_in && cnt == DELAY) begin
            ack_out <= 1'b1;
            for (int k = 0; k < 4; k++) begin
                rdata_out[8*k +: 8] <= mem[8'(bus_in.addr + k)];
                if (bus_in.we && k <= bus_in.size) begin
                    mem[8'(bus_in.addr + k)] <= bus_in.wdata[8*k +: 8];
                end
            end
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : bus_mem_model
`default_nettype wire

// ==== dlink_core.sv ====
/*
 * debug data-link layer: instruction decode, memory access, error lockout,
 * guard time before responses, and the response byte buffer.
 * assumes the uart front end strips sync characters, measures the bit
 * period and hands over characters on the same clock.
 */
// Operation
// - on error, lock out until break
// - record parity, contention, frame, timeout code
// - idle guard bits before first response
// - each guard bit one bit period
// - guard is minimum; debugger waits to timeout
// - at least two guard bits recommended
// - direct load: address in, data out
// - repeated direct load never auto-increments address
// - direct load goes through bus, returns data
// - direct store acks address, then data
// - direct store sizes up to 32, repeatable
// - indirect load from pointer or pointer itself
// - pointer mode 2 stores pointer, acked
// - mode 0 stores, mode 1 also increments
// - indirect store data then ack on success
// - repeat up to 255, break aborts
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
// response buffer, flip-flop storage
module byte_fifo import dlink_pkg::*; #(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];        // storage words
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp; // write and read index
    logic [AW:0] cnt, next_cnt;            // words held
    logic push, pop;
    // honest full and empty
    assign in_ready_out = (cnt != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt != '0);
    assign out_data_out = mem[rp];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    // next pointers and contents
    always_comb begin
        next_mem = mem;
        next_wp = wp;
        next_rp = rp;
        next_cnt = cnt;
        if (push) begin
            next_mem[wp] = in_data_in;
            next_wp = (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
        end
        if (pop) begin
            next_rp = (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
        end
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    // registers
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (ce_in) begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
            mem <= next_mem;
        end
    end
endmodule : byte_fifo
////////////////////////////////////////////////////////////////////////
// data-link layer top
module dlink_core import dlink_pkg::*; #(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEFAULT
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire rx_t rx_in,
    input wire logic [3:0] guard_time_count_in,
    input wire logic [15:0] baud_period_in,
    input wire logic tx_ready_in,
    output logic tx_valid_out,
    output logic [7:0] tx_byte_out,
    output bus_t bus_out,
    input wire logic bus_ack_in,
    input wire logic [31:0] bus_rdata_in,
    output logic error_state_out,
    output logic [2:0] error_signature_out
);
    // operand bytes for a size code
    function automatic logic [2:0] nbytes(input logic [1:0] sz);
        nbytes = {1'b0, sz} + 3'h1;
    endfunction : nbytes
    // first state of an instruction or of a repeat pass
    function automatic state_t start_of(input logic [2:0] o, input logic [1:0] p);
        if (o == OP_LDS || o == OP_STS || (o == OP_ST && p == PTR_REG)) begin
            start_of = S_ADDR;
        end else if (o == OP_ST) begin
            start_of = S_DATA;
        end else if (o == OP_LD && p == PTR_REG) begin
            start_of = S_RESP;
        end else if (o == OP_LD) begin
            start_of = S_BUS;
        end else begin
            start_of = S_IDLE;
        end
    endfunction : start_of
    // address size code: a pointer write carries it in the data size field
    function automatic logic [1:0] asize(input logic [2:0] o, input logic [1:0] a,
        input logic [1:0] b);
        asize = (o == OP_ST) ? b : a;
    endfunction : asize
    ////////////////////////////////////////////////////////////////////
    // control state
    state_t st, next_st;
    logic [2:0] op, next_op;          // current opcode
    logic [1:0] sa, next_sa;          // address size code
    logic [1:0] sb, next_sb;          // data size code
    logic [1:0] pm, next_pm;          // pointer mode
    logic [1:0] idx, next_idx;        // byte index
    logic [31:0] addr, next_addr;     // collected address
    logic [31:0] data, next_data;     // collected or returned data
    logic [31:0] ptr, next_ptr;       // internal pointer
    logic [7:0] rpt, next_rpt;        // remaining repeats
    logic [31:0] tmo, next_tmo;       // bus wait counter
    logic stage2, next_stage2;        // direct store data phase
    logic [2:0] sig, next_sig;        // error signature
    bus_t bus, next_bus;
    logic fin;                        // instruction pass finished
    logic rx_err;
    // response buffer feed
    logic f_in_v, f_in_r, f_out_v, f_out_r;
    logic [7:0] f_in_d, f_out_d;
    assign rx_err = rx_in.valid && (rx_in.parity_err || rx_in.frame_err || rx_in.contend_err);
    assign f_in_v = (st == S_RESP) || (st == S_ACK);
    assign f_in_d = (st == S_ACK) ? ACK_CHAR : data[{idx, 3'b000} +: 8];
    // instruction sequencer
    always_comb begin
        next_st = st;
        next_op = op;
        next_sa = sa;
        next_sb = sb;
        next_pm = pm;
        next_idx = idx;
        next_addr = addr;
        next_data = data;
        next_ptr = ptr;
        next_rpt = rpt;
        next_tmo = tmo;
        next_stage2 = stage2;
        next_sig = sig;
        next_bus = bus;
        fin = 1'b0;
        case (st)
            // wait for an instruction byte
            S_IDLE: begin
                if (rx_in.valid) begin
                    next_op = rx_in.data[OP_LSB +: 3];
                    next_sa = rx_in.data[SA_LSB +: 2];
                    next_pm = rx_in.data[PTR_LSB +: 2];
                    next_sb = rx_in.data[SB_LSB +: 2];
                    next_idx = '0;
                    next_stage2 = 1'b0;
                    next_data = ptr;
                    if (rx_in.data[OP_LSB +: 3] == OP_RPT) begin
                        next_st = S_RPT;
                    end else begin
                        next_st = start_of(rx_in.data[OP_LSB +: 3], rx_in.data[PTR_LSB +: 2]);
                    end
                end
            end
            // one repeat byte, capped at 255 by width
            S_RPT: begin
                if (rx_in.valid) begin
                    next_rpt = rx_in.data;
                    next_st = S_IDLE;
                end
            end
            S_ADDR: begin
                if (rx_in.valid) begin
                    // a short address never inherits upper bytes of the last one
                    if (idx == 2'h0) begin
                        next_addr = '0;
                    end
                    next_addr[{idx, 3'b000} +: 8] = rx_in.data;
                    next_idx = idx + 2'h1;
                    if ({1'b0, idx} == nbytes(asize(op, sa, sb)) - 3'h1) begin
                        next_idx = '0;
                        if (op == OP_ST) begin
                            next_ptr = next_addr;
                            next_st = S_ACK;
                        end else if (op == OP_STS) begin
                            next_st = S_ACK;
                        end else begin
                            next_st = S_BUS;
                        end
                    end
                end
            end
            S_DATA: begin
                if (rx_in.valid) begin
                    next_data[{idx, 3'b000} +: 8] = rx_in.data;
                    next_idx = idx + 2'h1;
                    if ({1'b0, idx} == nbytes(sb) - 3'h1) begin
                        next_idx = '0;
                        next_st = S_BUS;
                    end
                end
            end
            // bus access with time-out
            S_BUS: begin
                next_bus.req = 1'b1;
                next_bus.we = (op == OP_STS) || (op == OP_ST);
                next_bus.size = sb;
                // direct forms use the received address only
                next_bus.addr = (op == OP_LDS || op == OP_STS) ? addr : ptr;
                next_bus.wdata = data;
                next_tmo = tmo + 32'h1;
                if (bus.req && bus_ack_in) begin
                    next_bus.req = 1'b0;
                    next_tmo = '0;
                    next_data = bus_rdata_in;
                    next_st = bus.we ? S_ACK : S_RESP;
                    if ((op == OP_LD || op == OP_ST) && pm == PTR_INC) begin
                        next_ptr = ptr + {29'h0, nbytes(sb)};
                    end
                end else if (tmo == 32'(TIMEOUT_CYCLES - 1)) begin
                    next_bus.req = 1'b0;
                    next_tmo = '0;
                    next_sig = SIG_TIMEOUT;
                    next_st = S_ERR;
                end
            end
            // send data bytes, low byte first
            S_RESP: begin
                if (f_in_r) begin
                    next_idx = idx + 2'h1;
                    if ({1'b0, idx} == nbytes(sb) - 3'h1) begin
                        next_idx = '0;
                        fin = 1'b1;
                    end
                end
            end
            S_ACK: begin
                if (f_in_r) begin
                    if (op == OP_STS && !stage2) begin
                        next_stage2 = 1'b1;
                        next_st = S_DATA;
                    end else begin
                        fin = 1'b1;
                    end
                end
            end
            S_ERR: begin
                next_st = S_ERR;
            end
            default: begin
                next_st = S_IDLE;
            end
        endcase
        // run again without a new instruction byte
        if (fin) begin
            if (rpt != 8'h0 && !(op == OP_ST && pm == PTR_REG)) begin
                next_rpt = rpt - 8'h1;
                next_stage2 = 1'b0;
                next_data = ptr;
                next_st = start_of(op, pm);
            end else begin
                next_rpt = 8'h0;
                next_st = S_IDLE;
            end
        end
        // error entry; break wins over it and clears state, repeats, byte index, time-out and bus request, keeping the error signature and pointer
        if (rx_in.valid && rx_in.brk) begin
            next_st = S_IDLE;
            next_rpt = 8'h0;
            next_idx = '0;
            next_tmo = '0;
            next_bus.req = 1'b0;
        end else if (rx_err && st != S_ERR) begin
            next_st = S_ERR;
            next_bus.req = 1'b0;
            next_sig = rx_in.parity_err ? SIG_PARITY : rx_in.frame_err ? SIG_FRAME : SIG_CONTEND;
        end
    end
    // control registers
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= S_IDLE;
            op <= '0;
            sa <= '0;
            sb <= '0;
            pm <= '0;
            idx <= '0;
            addr <= '0;
            data <= '0;
            ptr <= '0;
            rpt <= '0;
            tmo <= '0;
            stage2 <= 1'b0;
            sig <= SIG_NONE;
            bus <= '0;
            error_state_out <= 1'b0;
        end else if (ce_in) begin
            st <= next_st;
            op <= next_op;
            sa <= next_sa;
            sb <= next_sb;
            pm <= next_pm;
            idx <= next_idx;
            addr <= next_addr;
            data <= next_data;
            ptr <= next_ptr;
            rpt <= next_rpt;
            tmo <= next_tmo;
            stage2 <= next_stage2;
            sig <= next_sig;
            bus <= next_bus;
            error_state_out <= (next_st == S_ERR);
        end
    end
    assign bus_out = bus;
    assign error_signature_out = sig;
    ////////////////////////////////////////////////////////////////////
    // response buffer, drained by the transmitter
    byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) byte_fifo_inst (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .in_valid_in(f_in_v),
        .in_ready_out(f_in_r),
        .in_data_in(f_in_d),
        .out_valid_out(f_out_v),
        .out_ready_in(f_out_r),
        .out_data_out(f_out_d)
    );
    ////////////////////////////////////////////////////////////////////
    // guard time and transmit register
    logic turn, next_turn;            // line last carried receive data
    logic grun, next_grun;            // guard interval running
    logic [19:0] gcnt, next_gcnt;     // guard cycles left
    logic next_tx_valid;
    logic [7:0] next_tx_byte;
    logic [3:0] gbits;
    // never fewer than two guard bits
    assign gbits = (guard_time_count_in < GUARD_MIN) ? GUARD_MIN : guard_time_count_in;
    assign f_out_r = f_out_v && !turn && (!tx_valid_out || tx_ready_in);
    always_comb begin
        next_turn = turn;
        next_grun = grun;
        next_gcnt = gcnt;
        next_tx_valid = tx_valid_out;
        next_tx_byte = tx_byte_out;
        if (tx_valid_out && tx_ready_in) begin
            next_tx_valid = 1'b0;
        end
        // count guard bits at the current bit period
        if (turn && f_out_v && !grun) begin
            next_grun = 1'b1;
            next_gcnt = 20'(gbits * baud_period_in);
        end else if (grun) begin
            if (gcnt <= 20'h1) begin
                next_grun = 1'b0;
                next_turn = 1'b0;
            end else begin
                next_gcnt = gcnt - 20'h1;
            end
        end
        if (f_out_r) begin
            next_tx_valid = 1'b1;
            next_tx_byte = f_out_d;
        end
        // received character marks a direction change
        if (rx_in.valid) begin
            next_turn = 1'b1;
        end
    end
    // transmit registers
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            turn <= 1'b0;
            grun <= 1'b0;
            gcnt <= '0;
            tx_valid_out <= 1'b0;
            tx_byte_out <= '0;
        end else if (ce_in) begin
            turn <= next_turn;
            grun <= next_grun;
            gcnt <= next_gcnt;
            tx_valid_out <= next_tx_valid;
            tx_byte_out <= next_tx_byte;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // checks
    err_entry_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ce_in && rx_err && !rx_in.brk |=> error_state_out)
        else $error("error did not lock out");
    err_hold_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ce_in && st == S_ERR && !(rx_in.valid && rx_in.brk) |=> st == S_ERR && !bus.req)
        else $error("left error state without break");
    sig_parity_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ce_in && st != S_ERR && rx_in.valid && rx_in.parity_err && !rx_in.brk
        |=> error_signature_out == SIG_PARITY)
        else $error("parity signature missing");
    guard_first_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
        $rose(tx_valid_out) |-> !$past(turn))
        else $error("response sent without guard");
    guard_len_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ce_in && turn && f_out_v && !grun |=> grun && gcnt == 20'($past(gbits) * $past(baud_period_in)))
        else $error("guard length wrong");
    timeout_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ce_in && st == S_BUS && !bus_ack_in && !rx_in.valid && tmo == 32'(TIMEOUT_CYCLES - 1)
        |=> error_signature_out == SIG_TIMEOUT && error_state_out)
        else $error("time-out not flagged");
    lds_noinc_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ce_in && st == S_BUS && op == OP_LDS && bus_ack_in |=> ptr == $past(ptr))
        else $error("direct load moved pointer");
    ptr_write_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ce_in && st == S_ADDR && op == OP_ST && rx_in.valid && !rx_err && !rx_in.brk
        && {1'b0, idx} == nbytes(asize(op, sa, sb)) - 3'h1
        |=> st == S_ACK && f_in_v && f_in_d == ACK_CHAR
        && ptr[{$past(idx), 3'b000} +: 8] == $past(rx_in.data))
        else $error("pointer write not acknowledged");
    post_inc_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ce_in && st == S_BUS && bus.req && bus_ack_in && op == OP_ST && pm == PTR_INC
        && !rx_in.brk && !rx_err |=> ptr == $past(ptr) + {29'h0, nbytes($past(sb))})
        else $error("post-increment wrong");
endmodule : dlink_core
`default_nettype wire

// ==== dlink_core_tb_top.sv ====
/*
 * testbench of the debug data-link layer, character level.
 * assumes the front end strips sync characters; a memory model answers the bus.
 */
`timescale 1ns/1ns
`default_nettype none
module dlink_core_tb_top import dlink_pkg::*;;
    localparam int BAUD = 4; // cycles per bit
    localparam int GUARD = 3; // guard bits, at least two
    localparam int GAP = GUARD * BAUD; // least idle before a response
    logic clock_in = 1'b0; // starts low, so no false edge at time zero
    logic rstn_in, ce_in, tx_ready_in, tx_valid_out, bus_ack_in, stall, error_state_out;
    logic [3:0] guard_cnt; // guard bits asked of the design
    rx_t rx_in; // received character
    bus_t bus_out; // bus request
    logic [7:0] tx_byte_out;
    logic [31:0] bus_rdata_in;
    logic [2:0] error_signature_out;
    int num_errors = 0;
    int checked = 0;
    dlink_core #(.TIMEOUT_CYCLES(64)) dlink_core_inst (.clock_in(clock_in), .rstn_in(rstn_in),
        .ce_in(ce_in), .rx_in(rx_in), .guard_time_count_in(guard_cnt),
        .baud_period_in(16'(BAUD)), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
        .tx_byte_out(tx_byte_out), .bus_out(bus_out), .bus_ack_in(bus_ack_in),
        .bus_rdata_in(bus_rdata_in), .error_state_out(error_state_out),
        .error_signature_out(error_signature_out));
    bus_mem_model #(.DELAY(3)) bus_mem_model_inst (.clock_in(clock_in), .bus_in(bus_out),
        .stall_in(stall), .ack_out(bus_ack_in), .rdata_out(bus_rdata_in));
    initial begin
        forever #20 clock_in = ~clock_in;
    end
    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic conclude();
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : check
    function automatic logic [7:0] init_val(input logic [7:0] a);
        return a ^ 8'hA5; // memory model start contents
    endfunction : init_val
    // one character for one cycle; flags are parity, frame, contention
    // the front end eats each 0x55 sync, only the op byte arrives here
    task automatic send(input logic [7:0] b, input logic [2:0] e = 3'h0, input logic brk = 1'b0);
        rx_in = '{1'b1, brk, e[2], e[1], e[0], b};
        @(negedge clock_in);
        rx_in = '0;
        @(negedge clock_in);
    endtask : send
    // wait for a response byte, take it, check value and idle gap
    task automatic get_tx(input logic [7:0] exp, input int min_gap);
        int n;
        n = 0;
        while (tx_valid_out !== 1'b1) begin
            @(negedge clock_in);
            n++;
            if (n > 3000) begin // wait bounded at 3000 cycles
                num_errors++;
                conclude();
            end
        end
        check(tx_byte_out, exp);
        check(n >= min_gap, 1'b1);
        tx_ready_in = 1'b1;
        @(negedge clock_in);
        tx_ready_in = 1'b0;
    endtask : get_tx
    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge clock_in);
            check({tx_valid_out, bus_out.req}, 2'h0);
        end
    endtask : quiet
    task automatic direct_load_op(input logic [7:0] a, input logic [7:0] exp);
        send({OP_LDS, 5'h0});
        send(a);
        get_tx(exp, GAP);
    endtask : direct_load_op
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_store_load();
        send({OP_STS, 5'h0});
        send(8'h20);
        get_tx(ACK_CHAR, GAP);
        send(8'h3C);
        get_tx(ACK_CHAR, GAP);
        direct_load_op(8'h20, 8'h3C);
    endtask : t_store_load
    task automatic t_pointer();
        send({OP_ST, 1'b0, PTR_REG, 2'h0});
        send(8'h30);
        get_tx(ACK_CHAR, GAP);
        send({OP_ST, 1'b0, PTR_INC, 2'h1});
        send(8'h11);
        send(8'h22);
        get_tx(ACK_CHAR, GAP);
        send({OP_LD, 1'b0, PTR_REG, 2'h0});
        get_tx(8'h32, GAP);
        send({OP_LD, 1'b0, PTR_AT, 2'h0});
        get_tx(init_val(8'h32), GAP);
        direct_load_op(8'h31, 8'h22);
    endtask : t_pointer
    task automatic t_errors();
        logic [2:0] flags [3] = '{3'h4, 3'h2, 3'h1};
        logic [2:0] sigs [3] = '{SIG_PARITY, SIG_FRAME, SIG_CONTEND};
        for (int i = 0; i < 3; i++) begin
            send(8'h00, flags[i]);
            repeat (2) @(negedge clock_in);
            check(error_state_out, 1'b1);
            check(error_signature_out, sigs[i]);
            send({OP_LDS, 5'h0});
            send(8'h10);
            quiet(30);
            send(8'h00, 3'h0, 1'b1);
            repeat (2) @(negedge clock_in);
            check(error_state_out, 1'b0);
            check(error_signature_out, sigs[i]);
        end
    endtask : t_errors
    task automatic t_repeat();
        send({OP_RPT, 5'h0});
        send(8'h01);
        direct_load_op(8'h10, init_val(8'h10));
        send(8'h11);
        get_tx(init_val(8'h11), GAP);
        send(8'hE0);
        quiet(20);
        send({OP_RPT, 5'h0});
        send(8'h01);
        send({OP_ST, 1'b0, PTR_INC, 2'h0});
        send(8'h5A);
        get_tx(ACK_CHAR, GAP);
        send(8'h6B);
        get_tx(ACK_CHAR, GAP);
        direct_load_op(8'h33, 8'h6B);
    endtask : t_repeat
    task automatic t_timeout();
        int n;
        stall = 1'b1;
        send({OP_LDS, 5'h0});
        send(8'h12);
        for (n = 0; n < 200 && error_state_out !== 1'b1; n++) @(negedge clock_in);
        if (n == 200) begin
            num_errors++;
            conclude();
        end
        check(error_state_out, 1'b1);
        check(error_signature_out, SIG_TIMEOUT);
        check(bus_out.req, 1'b0);
        stall = 1'b0;
        send(8'h00, 3'h0, 1'b1);
        direct_load_op(8'h12, init_val(8'h12));
        guard_cnt = 4'h0;
        send({OP_LDS, 5'h0});
        send(8'h12);
        get_tx(init_val(8'h12), int'(GUARD_MIN) * BAUD);
    endtask : t_timeout
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rstn_in = 1'b0;
        ce_in = 1'b1;
        rx_in = '0;
        tx_ready_in = 1'b0;
        stall = 1'b0;
        guard_cnt = 4'(GUARD);
        repeat (3) @(negedge clock_in);
        rstn_in = 1'b1;
        @(negedge clock_in);
        t_store_load();
        t_pointer();
        t_errors();
        t_repeat();
        t_timeout();
        conclude();
    end
endmodule : dlink_core_tb_top
`default_nettype wire

// ==== dlink_pkg.sv ====
/*
 * shared constants and carrier types of the debug data-link layer.
 * assumes a byte-level uart front end and a simple word bus behind it.
 */
`default_nettype none
package dlink_pkg;
    // instruction byte fields
    localparam int OP_LSB = 5;
    localparam int PTR_LSB = 2;
    localparam int SA_LSB = 2;
    localparam int SB_LSB = 0;
    // opcodes
    localparam logic [2:0] OP_LDS = 3'h0;
    localparam logic [2:0] OP_LD = 3'h1;
    localparam logic [2:0] OP_STS = 3'h2;
    localparam logic [2:0] OP_ST = 3'h3;
    localparam logic [2:0] OP_RPT = 3'h5;
    // pointer modes
    localparam logic [1:0] PTR_AT = 2'h0;
    localparam logic [1:0] PTR_INC = 2'h1;
    localparam logic [1:0] PTR_REG = 2'h2;
    // error signature codes
    localparam logic [2:0] SIG_NONE = 3'h0;
    localparam logic [2:0] SIG_PARITY = 3'h1;
    localparam logic [2:0] SIG_FRAME = 3'h2;
    localparam logic [2:0] SIG_TIMEOUT = 3'h3;
    localparam logic [2:0] SIG_CONTEND = 3'h4;
    // acknowledge character and guard floor
    localparam logic [7:0] ACK_CHAR = 8'h40;
    localparam logic [3:0] GUARD_MIN = 4'h2;
    // response buffer shape and bus time-out
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int TIMEOUT_CYCLES_DEFAULT = 65536;
    // one received character with its line status
    typedef struct packed {
        logic valid;
        logic brk;
        logic parity_err;
        logic frame_err;
        logic contend_err;
        logic [7:0] data;
    } rx_t;
    // system bus request
    typedef struct packed {
        logic req;
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bus_t;
    typedef enum {S_IDLE, S_RPT, S_ADDR, S_DATA, S_BUS, S_RESP, S_ACK, S_ERR} state_t;
endpackage : dlink_pkg
`default_nettype wire
